// ==== src/op_pkg.sv ====
/*
 Shared constants and types for the increment/OR/return execution block.
 Assumes a single core clock and a synchronous active-high reset.
*/
`default_nettype none
package op_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int PC_W = 13;
   localparam int OPC_W = 3;
   localparam int DEST_TO_ACC = 0;
   localparam int INT_EN_BIT = 7;
   localparam int RET_CYCLES = 2;
   localparam int SINGLE_CYCLES = 1;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] ICR_RESET = 8'h00;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_ADD_ONE = 3'h1,
      OP_OR_ACC = 3'h2,
      OP_RET_INT = 3'h3,
      OP_RET_LIT = 3'h4,
      OP_RET_SUB = 3'h5
   } opcode_e;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RET2 = 2'b01
   } exec_state_e;
endpackage
`default_nettype wire

// ==== src/alu_unit.sv ====
/*
 Combinational ALU: add-one and inclusive OR with zero detect.
 Assumes operands are stable for the cycle in which they are used.
*/
`default_nettype none
module alu_unit
   import op_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input wire logic inc_sel_in,
   input wire logic [WIDTH-1:0] file_in,
   input wire logic [WIDTH-1:0] acc_in,
   output logic [WIDTH-1:0] result_out,
   output logic zero_out
);
   always_comb begin
      if (inc_sel_in) begin
         result_out = WIDTH'(file_in + 1'b1);
      end else begin
         result_out = acc_in | file_in;
      end
      zero_out = (result_out == '0);
   end
endmodule // alu_unit
`default_nettype wire

// ==== src/op_exec.sv ====
/*
 Execution of add-one-to-file, or-accumulator-with-file and the three returns.
 Assumes the fetch side presents one decoded op per cycle with OP_VALID_IN,
 holds no new op while BUSY_OUT is high, and the file/stack data are combinational
 reads of FILE_ADDR_IN and of the stack top entry.
*/
`default_nettype none
module op_exec
   import op_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int AW = ADDR_W,
   parameter int PW = PC_W
) (
   input wire logic CORE_CLK_IN,
   input wire logic RESET_IN,
   input wire logic OP_VALID_IN,
   input wire logic [OPC_W-1:0] OPCODE_IN,
   input wire logic [AW-1:0] FILE_ADDR_IN,
   input wire logic DEST_SEL_IN,
   input wire logic [DW-1:0] LITERAL_IN,
   input wire logic [DW-1:0] FILE_DATA_IN,
   input wire logic [PW-1:0] STACK_TOP_ENTRY_IN,
   output logic [DW-1:0] ACC_OUT,
   output logic ZERO_FLAG_OUT,
   output logic [DW-1:0] INTERRUPT_CONTROL_REGISTER_OUT,
   output logic GLOBAL_INTERRUPT_ENABLE_OUT,
   output logic FILE_WR_OUT,
   output logic [AW-1:0] FILE_WR_ADDR_OUT,
   output logic [DW-1:0] FILE_WR_DATA_OUT,
   output logic STACK_POP_OUT,
   output logic PC_LOAD_OUT,
   output logic [PW-1:0] PC_VALUE_OUT,
   output logic BUSY_OUT,
   output logic DONE_OUT
);
   typedef struct packed {
      exec_state_e state;
      logic [DW-1:0] acc;
      logic zero;
      logic [DW-1:0] icr;
      logic file_wr;
      logic [AW-1:0] file_addr;
      logic [DW-1:0] file_data;
      logic pop;
      logic pc_load;
      logic [PW-1:0] pc;
      logic done;
      logic busy;
   } exec_s;

   exec_s state_ff;
   exec_s nxt_state;
   logic [DW-1:0] alu_result;
   logic alu_zero;
   logic is_ret;

   alu_unit #(.WIDTH(DW)) u_alu (
      .inc_sel_in(OPCODE_IN == OP_ADD_ONE),
      .file_in(FILE_DATA_IN),
      .acc_in(state_ff.acc),
      .result_out(alu_result),
      .zero_out(alu_zero)
   );

   function automatic logic op_is_return(input logic [OPC_W-1:0] op);
      op_is_return = (op == OP_RET_INT) || (op == OP_RET_LIT) || (op == OP_RET_SUB);
   endfunction

   assign is_ret = op_is_return(OPCODE_IN);

   always_comb begin
      nxt_state = state_ff;
      nxt_state.file_wr = 1'b0;
      nxt_state.pop = 1'b0;
      nxt_state.pc_load = 1'b0;
      nxt_state.done = 1'b0;
      nxt_state.busy = 1'b0;
      unique case (state_ff.state)
         ST_IDLE: begin
            if (OP_VALID_IN) begin
               if (OPCODE_IN == OP_ADD_ONE || OPCODE_IN == OP_OR_ACC) begin
                  nxt_state.zero = alu_zero;
                  nxt_state.done = 1'b1;
                  if (DEST_SEL_IN == 1'(DEST_TO_ACC)) begin
                     nxt_state.acc = alu_result;
                  end else begin
                     nxt_state.file_wr = 1'b1;
                     nxt_state.file_addr = FILE_ADDR_IN;
                     nxt_state.file_data = alu_result;
                  end
               end else if (is_ret) begin
                  // first cycle pops and loads; second cycle is the flushed slot
                  nxt_state.pop = 1'b1;
                  nxt_state.pc_load = 1'b1;
                  nxt_state.pc = STACK_TOP_ENTRY_IN;
                  nxt_state.state = ST_RET2;
                  // registered stall, so fetch sees a clean flop output
                  nxt_state.busy = 1'b1;
                  if (OPCODE_IN == OP_RET_INT) begin
                     nxt_state.icr[INT_EN_BIT] = 1'b1;
                  end
                  if (OPCODE_IN == OP_RET_LIT) begin
                     nxt_state.acc = LITERAL_IN;
                  end
               end
            end
         end
         ST_RET2: begin
            // slot of the discarded prefetch; nothing else moves
            nxt_state.state = ST_IDLE;
            nxt_state.done = 1'b1;
         end
         default: nxt_state.state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CORE_CLK_IN) begin
      if (RESET_IN) begin
         state_ff <= '{state: ST_IDLE, acc: ACC_RESET, zero: 1'b0, icr: ICR_RESET,
                       file_wr: 1'b0, file_addr: '0, file_data: '0, pop: 1'b0,
                       pc_load: 1'b0, pc: '0, done: 1'b0, busy: 1'b0};
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign ACC_OUT = state_ff.acc;
   assign ZERO_FLAG_OUT = state_ff.zero;
   assign INTERRUPT_CONTROL_REGISTER_OUT = state_ff.icr;
   assign GLOBAL_INTERRUPT_ENABLE_OUT = state_ff.icr[INT_EN_BIT];
   assign FILE_WR_OUT = state_ff.file_wr;
   assign FILE_WR_ADDR_OUT = state_ff.file_addr;
   assign FILE_WR_DATA_OUT = state_ff.file_data;
   assign STACK_POP_OUT = state_ff.pop;
   assign PC_LOAD_OUT = state_ff.pc_load;
   assign PC_VALUE_OUT = state_ff.pc;
   assign BUSY_OUT = state_ff.busy;
   assign DONE_OUT = state_ff.done;

   logic idle_take;
   assign idle_take = OP_VALID_IN && !BUSY_OUT;

   // op checks below look one edge after the op is taken; a_retint_enable and a_retsub_two also look at done one edge later
   a_inc_result: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_ADD_ONE && DEST_SEL_IN
      |=> FILE_WR_OUT && FILE_WR_DATA_OUT == DW'($past(FILE_DATA_IN) + 1'b1))
      else $error("add-one result wrong");
   a_inc_acc: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_ADD_ONE && !DEST_SEL_IN
      |=> ACC_OUT == DW'($past(FILE_DATA_IN) + 1'b1) && !FILE_WR_OUT)
      else $error("add-one to accumulator wrong");
   a_or_result: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_OR_ACC && !DEST_SEL_IN
      |=> ACC_OUT == ($past(ACC_OUT) | $past(FILE_DATA_IN)) && !FILE_WR_OUT)
      else $error("or result wrong");
   a_or_file: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_OR_ACC && DEST_SEL_IN
      |=> FILE_WR_OUT && FILE_WR_DATA_OUT == ($past(ACC_OUT) | $past(FILE_DATA_IN))
          && $stable(ACC_OUT))
      else $error("or to file wrong");
   a_zero_flag: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && (OPCODE_IN == OP_ADD_ONE || OPCODE_IN == OP_OR_ACC)
      |=> ZERO_FLAG_OUT == $past(alu_zero))
      else $error("zero flag wrong");
   a_dest_file: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_ADD_ONE && DEST_SEL_IN
      |=> $stable(ACC_OUT) && FILE_WR_ADDR_OUT == $past(FILE_ADDR_IN))
      else $error("destination select wrong");
   a_retint_enable: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_INT
      |=> GLOBAL_INTERRUPT_ENABLE_OUT && STACK_POP_OUT && PC_LOAD_OUT ##1 DONE_OUT)
      else $error("interrupt return wrong");
   // nothing in this block clears the enable bit, only reset does
   a_enable_sticky: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      GLOBAL_INTERRUPT_ENABLE_OUT |=> GLOBAL_INTERRUPT_ENABLE_OUT)
      else $error("interrupt enable dropped");
   a_retlit_acc: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_LIT
      |=> ACC_OUT == $past(LITERAL_IN) && $stable(ZERO_FLAG_OUT)
          && PC_VALUE_OUT == $past(STACK_TOP_ENTRY_IN))
      else $error("literal return wrong");
   a_retsub_two: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_SUB
      |=> BUSY_OUT && !DONE_OUT && $stable(ZERO_FLAG_OUT) ##1 DONE_OUT && !BUSY_OUT)
      else $error("subroutine return timing wrong");
   a_retsub_pc: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_SUB
      |=> STACK_POP_OUT && PC_LOAD_OUT && PC_VALUE_OUT == $past(STACK_TOP_ENTRY_IN))
      else $error("subroutine return target wrong");
   a_pop_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      STACK_POP_OUT |-> BUSY_OUT && PC_LOAD_OUT ##1 !STACK_POP_OUT && DONE_OUT)
      else $error("stack pop not a single pulse");
   a_ret_no_write: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && is_ret |=> !FILE_WR_OUT && !DONE_OUT)
      else $error("return wrote a file register");
   // an op offered in the second return cycle is dropped, not queued
   a_busy_refuse: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      BUSY_OUT && OP_VALID_IN |=> !FILE_WR_OUT && !STACK_POP_OUT && !PC_LOAD_OUT)
      else $error("op taken while busy");
   a_single_cycle: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_OR_ACC |=> DONE_OUT && !BUSY_OUT)
      else $error("single-cycle op not done");

   c_inc_zero: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_ADD_ONE ##1 ZERO_FLAG_OUT);
   c_ret_int: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_INT ##2 DONE_OUT);
   c_ret_lit: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_LIT);
   c_ret_sub: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_RET_SUB ##2 DONE_OUT);
   c_or_file: cover property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
      idle_take && OPCODE_IN == OP_OR_ACC && DEST_SEL_IN ##1 FILE_WR_OUT);
endmodule // op_exec
`default_nettype wire

// ==== bench/increment_or_return_ops_test.sv ====
/*
 Self-checking bench for op_exec: add-one, or-accumulator and the three returns.
 Assumes the file and stack reads are driven here as plain values, one op at a time.
*/
`default_nettype none
module increment_or_return_ops_test;
   timeunit 1ns;
   timeprecision 1ps;
   import op_pkg::*;
   logic clk, rst, vld, dsel, zf, int_en, fwr, pop, pcl, busy, done;
   logic [2:0] opc;
   logic [6:0] addr, fwa;
   logic [7:0] lit, fdat, acc, icr, fwd;
   logic [12:0] stk_top, pcv;
   int err_count = 0;
   int checked = 0;
   op_exec dut_u (.CORE_CLK_IN(clk), .RESET_IN(rst), .OP_VALID_IN(vld), .OPCODE_IN(opc),
      .FILE_ADDR_IN(addr), .DEST_SEL_IN(dsel), .LITERAL_IN(lit), .FILE_DATA_IN(fdat),
      .STACK_TOP_ENTRY_IN(stk_top), .ACC_OUT(acc), .ZERO_FLAG_OUT(zf),
      .INTERRUPT_CONTROL_REGISTER_OUT(icr), .GLOBAL_INTERRUPT_ENABLE_OUT(int_en),
      .FILE_WR_OUT(fwr), .FILE_WR_ADDR_OUT(fwa), .FILE_WR_DATA_OUT(fwd),
      .STACK_POP_OUT(pop), .PC_LOAD_OUT(pcl), .PC_VALUE_OUT(pcv), .BUSY_OUT(busy),
      .DONE_OUT(done));
   always #10 clk = ~clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // one op offered for one edge; results are read once that edge has landed
   task automatic send(input logic [2:0] op, input logic [6:0] a, input logic d,
                       input logic [7:0] l, input logic [7:0] f, input logic [12:0] t);
      @(posedge clk);
      vld <= 1'b1;
      opc <= op;
      addr <= a;
      dsel <= d;
      lit <= l;
      fdat <= f;
      stk_top <= t;
      @(posedge clk);
      vld <= 1'b0;
      #1;
   endtask
   // both cycles of a return: pc loads with busy high and no done, then busy drops and done pulses
   task automatic ret_chk(input logic [12:0] t);
      chk("pc_load", 16'h0001, 16'(pcl));
      chk("pc_value", 16'(t), 16'(pcv));
      chk("busy", 16'h0001, 16'(busy));
      chk("early_done", 16'h0000, 16'(done));
      @(posedge clk);
      #1;
      chk("done", 16'h0001, 16'(done));
      chk("busy_end", 16'h0000, 16'(busy));
   endtask
   task automatic t_acc_path;
      send(OP_ADD_ONE, 7'h12, 1'b0, 8'h00, 8'h41, 13'h0000);
      chk("acc", 16'h0042, 16'(acc));
      chk("file_wr", 16'h0000, 16'(fwr));
      chk("done", 16'h0001, 16'(done));
      send(OP_RET_LIT, 7'h00, 1'b0, 8'h00, 8'h00, 13'h1abc);
      chk("acc", 16'h0000, 16'(acc));
      chk("zero", 16'h0000, 16'(zf));
      ret_chk(13'h1abc);
      send(OP_OR_ACC, 7'h33, 1'b0, 8'h00, 8'h00, 13'h0000);
      chk("zero", 16'h0001, 16'(zf));
      chk("acc", 16'h0000, 16'(acc));
      $display("test acc_path done");
   endtask
   task automatic t_file_path;
      send(OP_ADD_ONE, 7'h7f, 1'b1, 8'h00, 8'hff, 13'h0000);
      chk("file_wr", 16'h0001, 16'(fwr));
      chk("wr_addr", 16'h007f, 16'(fwa));
      chk("wr_data", 16'h0000, 16'(fwd));
      chk("done", 16'h0001, 16'(done));
      send(OP_RET_SUB, 7'h00, 1'b0, 8'h00, 8'h00, 13'h0155);
      chk("pop", 16'h0001, 16'(pop));
      chk("zero", 16'h0001, 16'(zf));
      ret_chk(13'h0155);
      send(OP_RET_LIT, 7'h00, 1'b0, 8'h24, 8'h00, 13'h0c33);
      chk("acc", 16'h0024, 16'(acc));
      chk("zero", 16'h0001, 16'(zf));
      ret_chk(13'h0c33);
      send(OP_OR_ACC, 7'h05, 1'b1, 8'h00, 8'h81, 13'h0000);
      chk("wr_data", 16'h00a5, 16'(fwd));
      chk("zero", 16'h0000, 16'(zf));
      chk("acc", 16'h0024, 16'(acc));
      send(OP_OR_ACC, 7'h06, 1'b0, 8'h00, 8'h42, 13'h0000);
      chk("acc", 16'h0066, 16'(acc));
      chk("file_wr", 16'h0000, 16'(fwr));
      $display("test file_path done");
   endtask
   task automatic t_ret_int;
      chk("enable", 16'h0000, 16'(int_en));
      send(OP_RET_INT, 7'h00, 1'b0, 8'h00, 8'h00, 13'h0a5a);
      chk("pop", 16'h0001, 16'(pop));
      chk("enable", 16'h0001, 16'(int_en));
      chk("icr", 16'h0080, 16'(icr));
      ret_chk(13'h0a5a);
      $display("test ret_int done");
   endtask
   // an op offered in the second return cycle must be dropped
   task automatic t_busy_refuse;
      @(posedge clk);
      vld <= 1'b1;
      opc <= OP_RET_SUB;
      stk_top <= 13'h0777;
      @(posedge clk);
      opc <= OP_ADD_ONE;
      dsel <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
      #1;
      chk("file_wr", 16'h0000, 16'(fwr));
      chk("done", 16'h0001, 16'(done));
      @(posedge clk);
      #1;
      chk("file_wr", 16'h0000, 16'(fwr));
      chk("pc_value", 16'h0777, 16'(pcv));
      $display("test busy_refuse done");
   endtask
   // mid-run reset clears the enable bit and the accumulator
   task automatic t_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("enable", 16'h0000, 16'(int_en));
      chk("icr", 16'(ICR_RESET), 16'(icr));
      chk("acc", 16'(ACC_RESET), 16'(acc));
      chk("busy", 16'h0000, 16'(busy));
      $display("test reset done");
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      err_count++;
      tally_and_finish();
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      vld = 1'b0;
      opc = 3'h0;
      addr = 7'h00;
      dsel = 1'b0;
      lit = 8'h00;
      fdat = 8'h00;
      stk_top = 13'h0000;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_acc_path();
      t_file_path();
      t_ret_int();
      t_busy_refuse();
      t_reset();
      t_ret_int();
      tally_and_finish();
   end
endmodule // increment_or_return_ops_test
`default_nettype wire
